// file: hw/sensor_power_defs.vh
// register offsets, field positions, reset values and timing counts
// assumes the 20 MHz device clock; included by bare name in design files
`ifndef SENSOR_POWER_DEFS_VH
`define SENSOR_POWER_DEFS_VH

// ****************************************
// register offsets
// ****************************************
`define OFS_STREAM_MODE_CTRL 16'h0100
`define OFS_SOFT_RESET_CTRL 16'h0103
`define OFS_PAD_OUTPUT_ENABLE 16'h3002
`define OFS_PAD_OUTPUT_VALUE 16'h300d
`define OFS_PAD_OUTPUT_SELECT 16'h3010
`define OFS_PAD_DRIVE_STRENGTH 16'h3011

// ****************************************
// field positions
// ****************************************
`define BIT_STREAM_ON 0
`define BIT_SOFT_RESET 0
`define BIT_PAD_VSYNC 7
`define BIT_PAD_LINE_VALID 6
`define BIT_PAD_GPIO 0
`define DRIVE_HI 6
`define DRIVE_LO 5

// ****************************************
// reset values
// ****************************************
`define RST_STREAM_MODE_CTRL 8'h00
`define RST_PAD_OUTPUT_ENABLE 8'h00
`define RST_PAD_OUTPUT_VALUE 8'h00
`define RST_PAD_OUTPUT_SELECT 8'h00
`define RST_PAD_DRIVE_STRENGTH 8'h00

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 50
`define CLOCK_LOCK_NS 200000
`define CLOCK_LOCK_CYCLES (`CLOCK_LOCK_NS / `CLK_PERIOD_NS)
`define FIRST_FRAME_NS 10000000
`define FIRST_FRAME_CYCLES (`FIRST_FRAME_NS / `CLK_PERIOD_NS)
`define POR_STRETCH_CYCLES 16
`define LINE_TIME_CYCLES 100

`endif

// file: hw/por_lock_timer.v
// power-on reset stretcher and internal clock lock timer
// assumes coreSupplyGood is synchronous to clk and rises once supply is stable
`include "sensor_power_defs.vh"

module por_lock_timer
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // pins and supply
  input wire shutdown_n,
  input wire powerdown_n,
  input wire coreSupplyGood,
  // status
  output reg porActive,
  output reg clockLocked
);

  // header counts are plain integers; cut to counter width on purpose
  localparam integer POR_CYCLES = `POR_STRETCH_CYCLES;
  localparam integer LOCK_CYCLES = `CLOCK_LOCK_CYCLES;
  localparam [4:0] POR_LAST = POR_CYCLES[4:0] - 5'h01;
  localparam [11:0] LOCK_LAST = LOCK_CYCLES[11:0] - 12'h001;

  reg [4:0] porCnt;
  reg [11:0] lockCnt;

  // ****************************************
  // power-on reset
  // ****************************************
  // held while the core supply is not good, then stretched a few cycles
  always @(posedge clk)
  begin
    if (sys_rst || !coreSupplyGood)
    begin
      porCnt <= 5'h00;
      porActive <= 1'b1;
    end
    else if (porCnt != POR_LAST)
    begin
      porCnt <= porCnt + 5'h01;
      porActive <= 1'b1;
    end
    else
    begin
      porActive <= 1'b0;
    end
  end

  // ****************************************
  // lock timer
  // ****************************************
  // either pin low halts the clock and clears the count
  always @(posedge clk or negedge shutdown_n)
  begin
    if (!shutdown_n)
    begin
      lockCnt <= 12'h000;
      clockLocked <= 1'b0;
    end
    else if (sys_rst || porActive || !powerdown_n)
    begin
      lockCnt <= 12'h000;
      clockLocked <= 1'b0;
    end
    else if (lockCnt != LOCK_LAST)
    begin
      lockCnt <= lockCnt + 12'h001;
      clockLocked <= 1'b0;
    end
    else
    begin
      clockLocked <= 1'b1;
    end
  end

endmodule

// file: hw/sensor_power_standby_ctrl.v
// reset, standby and pad control of the image sensor
// assumes all inputs synchronous to clk; register port driven by the
// control bus slave, which this block enables or shuts off
`include "sensor_power_defs.vh"

// Operation
// - shutdown pin low resets the device asynchronously; host holds it 2 ms
// - internal clocks lock within 0.2 ms
// - first frame starts within 10 ms of streaming, plus exposure lines
// - standby request finishes the running frame first, else immediately
// - writing 1 to soft reset bit returns all registers to defaults
// - either pin low stops internal clock and clears internal counters
// - stream bit clear suspends activity, clock runs, registers kept
// - power-down pin standby gates clock, refuses bus, keeps registers and pads
// - shutdown standby powers down, resets registers, ignores the bus
// - after power-on reset device sits in software standby, bus active
// - internal power-on reset once the core supply is stable
// - two-bit field sets pad drive strength 1x to 4x
// - per-pad output enable bits, 0 input, 1 output
// - select bit makes sync pad drive its value register bit
// - MIPI output uses one, two or four lanes
// - in shutdown bus and sync pads float; after release MIPI pads drive high
module sensor_power_standby_ctrl
#(
  parameter FIRST_FRAME_CYCLES = `FIRST_FRAME_CYCLES,
  parameter LINE_CYCLES = `LINE_TIME_CYCLES
)
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // power pins and supply
  input wire shutdown_n,
  input wire powerdown_n,
  input wire coreSupplyGood,
  // register port
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regAddr,
  input wire [7:0] regWrData,
  output reg [7:0] regRdData,
  output reg regAck,
  output reg regRefused,
  // sensor core and MIPI side
  input wire frameInProgress,
  input wire frameEnd,
  input wire [15:0] exposureLines,
  input wire [1:0] laneSelect,
  output reg sensorActive,
  output reg frameStartGo,
  output reg swStandby,
  output reg hwStandby,
  output reg intClockRun,
  output reg [3:0] laneEnable,
  // video data path into pads
  input wire vsyncData,
  input wire lineValidData,
  // pads
  output reg vsyncOut,
  output reg vsyncOe,
  output reg lineValidOut,
  output reg lineValidOe,
  output reg gpioOut,
  output reg gpioOe,
  output reg [1:0] padDrive,
  output reg ctrlBusEnable,
  output reg mipiPadOe,
  output reg mipiPadIdleHigh
);

  // ****************************************
  // states and constants
  // ****************************************
  localparam [5:0] ST_HALT = 6'h01;
  localparam [5:0] ST_SWSTBY = 6'h02;
  localparam [5:0] ST_STARTDLY = 6'h04;
  localparam [5:0] ST_EXPDLY = 6'h08;
  localparam [5:0] ST_STREAM = 6'h10;
  localparam [5:0] ST_DRAIN = 6'h20;
  localparam [23:0] START_LAST = FIRST_FRAME_CYCLES[23:0] - 24'h000001;
  localparam [15:0] LINE_LAST = LINE_CYCLES[15:0] - 16'h0001;

  // 00 one lane, 01 two lanes, else four
  function [3:0] laneMask;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: laneMask = 4'h1;
        2'h1: laneMask = 4'h3;
        default: laneMask = 4'hf;
      endcase
    end
  endfunction

  wire porActive;
  wire clockLocked;
  reg [7:0] streamCtrl;
  reg [7:0] padEnable;
  reg [7:0] padValue;
  reg [7:0] padSelect;
  reg [7:0] padStrength;
  reg softRst;
  reg [5:0] state;
  reg [5:0] next_state;
  reg [23:0] startCnt;
  reg [15:0] cycCnt;
  reg [15:0] lineCnt;
  wire busOpen;
  wire access;
  wire regRst;
  wire streamOn;

  por_lock_timer lockTimer
  (
    .clk(clk),
    .sys_rst(sys_rst),
    .shutdown_n(shutdown_n),
    .powerdown_n(powerdown_n),
    .coreSupplyGood(coreSupplyGood),
    .porActive(porActive),
    .clockLocked(clockLocked)
  );

  // the bus is open in software standby and beyond, never with a pin low
  assign busOpen = shutdown_n && powerdown_n && !porActive;
  assign access = regWrite || regRead;
  assign regRst = sys_rst || porActive || softRst;
  assign streamOn = streamCtrl[`BIT_STREAM_ON];

  // ****************************************
  // register file
  // ****************************************
  // shutdown clears asynchronously; power-down keeps contents untouched
  always @(posedge clk or negedge shutdown_n)
  begin
    if (!shutdown_n)
    begin
      streamCtrl <= `RST_STREAM_MODE_CTRL;
      padEnable <= `RST_PAD_OUTPUT_ENABLE;
      padValue <= `RST_PAD_OUTPUT_VALUE;
      padSelect <= `RST_PAD_OUTPUT_SELECT;
      padStrength <= `RST_PAD_DRIVE_STRENGTH;
      softRst <= 1'b0;
      regRdData <= 8'h00;
      regAck <= 1'b0;
      regRefused <= 1'b0;
    end
    else if (regRst)
    begin
      streamCtrl <= `RST_STREAM_MODE_CTRL;
      padEnable <= `RST_PAD_OUTPUT_ENABLE;
      padValue <= `RST_PAD_OUTPUT_VALUE;
      padSelect <= `RST_PAD_OUTPUT_SELECT;
      padStrength <= `RST_PAD_DRIVE_STRENGTH;
      softRst <= 1'b0;
      regRdData <= 8'h00;
      regAck <= 1'b0;
      regRefused <= access && !busOpen;
    end
    else
    begin
      regAck <= access && busOpen;
      regRefused <= access && !busOpen;
      softRst <= 1'b0;
      if (regWrite && busOpen)
      begin
        case (regAddr)
          `OFS_STREAM_MODE_CTRL: streamCtrl <= regWrData;
          `OFS_SOFT_RESET_CTRL: softRst <= regWrData[`BIT_SOFT_RESET];
          `OFS_PAD_OUTPUT_ENABLE: padEnable <= regWrData;
          `OFS_PAD_OUTPUT_VALUE: padValue <= regWrData;
          `OFS_PAD_OUTPUT_SELECT: padSelect <= regWrData;
          `OFS_PAD_DRIVE_STRENGTH: padStrength <= regWrData;
          default: softRst <= 1'b0;
        endcase
      end
      // soft reset bit is self-clearing and reads back as zero
      if (regRead && busOpen)
      begin
        case (regAddr)
          `OFS_STREAM_MODE_CTRL: regRdData <= streamCtrl;
          `OFS_PAD_OUTPUT_ENABLE: regRdData <= padEnable;
          `OFS_PAD_OUTPUT_VALUE: regRdData <= padValue;
          `OFS_PAD_OUTPUT_SELECT: regRdData <= padSelect;
          `OFS_PAD_DRIVE_STRENGTH: regRdData <= padStrength;
          default: regRdData <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // power mode sequencer
  // ****************************************
  // next state; halt whenever the internal clock is not locked
  always @*
  begin
    next_state = state;
    if (!clockLocked || !powerdown_n)
    begin
      next_state = ST_HALT;
    end
    else
    begin
      case (state)
        ST_HALT: next_state = ST_SWSTBY;
        ST_SWSTBY:
        begin
          if (streamOn)
            next_state = ST_STARTDLY;
        end
        ST_STARTDLY:
        begin
          if (!streamOn)
            next_state = ST_SWSTBY;
          else if (startCnt == START_LAST)
            next_state = ST_EXPDLY;
        end
        ST_EXPDLY:
        begin
          if (!streamOn)
            next_state = ST_SWSTBY;
          else if (lineCnt >= exposureLines)
            next_state = ST_STREAM;
        end
        ST_STREAM:
        begin
          // a frame on the wire is finished before standby
          if (!streamOn && frameInProgress && !frameEnd)
            next_state = ST_DRAIN;
          else if (!streamOn)
            next_state = ST_SWSTBY;
        end
        ST_DRAIN:
        begin
          if (frameEnd)
            next_state = ST_SWSTBY;
        end
        default: next_state = ST_HALT;
      endcase
    end
  end

  // state, delay counters and mode outputs
  always @(posedge clk or negedge shutdown_n)
  begin
    if (!shutdown_n)
    begin
      state <= ST_HALT;
      startCnt <= 24'h000000;
      cycCnt <= 16'h0000;
      lineCnt <= 16'h0000;
      sensorActive <= 1'b0;
      frameStartGo <= 1'b0;
      swStandby <= 1'b0;
      hwStandby <= 1'b1;
      intClockRun <= 1'b0;
    end
    else if (sys_rst || porActive)
    begin
      state <= ST_HALT;
      startCnt <= 24'h000000;
      cycCnt <= 16'h0000;
      lineCnt <= 16'h0000;
      sensorActive <= 1'b0;
      frameStartGo <= 1'b0;
      swStandby <= 1'b0;
      hwStandby <= 1'b1;
      intClockRun <= 1'b0;
    end
    else
    begin
      state <= next_state;
      // counters run only in their own state, so a pin drop clears them
      if (next_state == ST_STARTDLY && state == ST_STARTDLY)
        startCnt <= startCnt + 24'h000001;
      else
        startCnt <= 24'h000000;
      if (next_state == ST_EXPDLY && state == ST_EXPDLY)
      begin
        if (cycCnt == LINE_LAST)
        begin
          cycCnt <= 16'h0000;
          lineCnt <= lineCnt + 16'h0001;
        end
        else
        begin
          cycCnt <= cycCnt + 16'h0001;
        end
      end
      else
      begin
        cycCnt <= 16'h0000;
        lineCnt <= 16'h0000;
      end
      frameStartGo <= (state == ST_EXPDLY) && (next_state == ST_STREAM);
      sensorActive <= (next_state == ST_STREAM) || (next_state == ST_DRAIN);
      swStandby <= (next_state == ST_SWSTBY);
      hwStandby <= (next_state == ST_HALT);
      // clock keeps running in software standby, stops with a pin low or while the lock timer has not locked
      intClockRun <= powerdown_n && clockLocked;
    end
  end

  // ****************************************
  // pads
  // ****************************************
  // registers keep their values under power-down, so pads hold their level
  always @(posedge clk or negedge shutdown_n)
  begin
    if (!shutdown_n)
    begin
      vsyncOut <= 1'b0;
      vsyncOe <= 1'b0;
      lineValidOut <= 1'b0;
      lineValidOe <= 1'b0;
      gpioOut <= 1'b0;
      gpioOe <= 1'b0;
      padDrive <= 2'h0;
      ctrlBusEnable <= 1'b0;
      mipiPadOe <= 1'b0;
      mipiPadIdleHigh <= 1'b0;
      laneEnable <= 4'h0;
    end
    else
    begin
      vsyncOe <= padEnable[`BIT_PAD_VSYNC];
      lineValidOe <= padEnable[`BIT_PAD_LINE_VALID];
      gpioOe <= padEnable[`BIT_PAD_GPIO];
      vsyncOut <= padSelect[`BIT_PAD_VSYNC] ? padValue[`BIT_PAD_VSYNC] : vsyncData;
      lineValidOut <= padSelect[`BIT_PAD_LINE_VALID] ? padValue[`BIT_PAD_LINE_VALID] : lineValidData;
      gpioOut <= padValue[`BIT_PAD_GPIO];
      padDrive <= padStrength[`DRIVE_HI:`DRIVE_LO];
      ctrlBusEnable <= busOpen;
      mipiPadOe <= 1'b1;
      mipiPadIdleHigh <= !sensorActive;
      laneEnable <= laneMask(laneSelect);
    end
  end

endmodule

// file: sim/power_ctrl_checker.sv
// checker for the reset, standby and pad block
// sees only top-level ports; bound into every instance of the top
module power_ctrl_checker
#(
  parameter FIRST_FRAME_CYCLES = 20,
  parameter LINE_CYCLES = 4
)
(
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // pins
  input wire shutdown_n,
  input wire powerdown_n,
  // register port
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regAddr,
  input wire [7:0] regWrData,
  input wire regAck,
  input wire regRefused,
  // sequencer
  input wire frameInProgress,
  input wire frameEnd,
  input wire [15:0] exposureLines,
  input wire [1:0] laneSelect,
  input wire sensorActive,
  input wire frameStartGo,
  input wire swStandby,
  input wire hwStandby,
  input wire intClockRun,
  input wire [3:0] laneEnable,
  // pads
  input wire [1:0] padDrive,
  input wire ctrlBusEnable,
  input wire mipiPadOe
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [31:0] waitCnt;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst || !shutdown_n);

  // cycles out of standby; bounds the first frame start
  always @(posedge clk)
  begin
    if (sys_rst || swStandby || hwStandby)
      waitCnt <= 32'h0;
    else
      waitCnt <= waitCnt + 32'h1;
  end

  // soft reset write and the cycle after it are left out: no answer promised
  a_answer_once: assert property ((regWrite || regRead) && !(regWrite && regAddr == 16'h0103)
    && !$past(regWrite && regAddr == 16'h0103) |=> regAck ^ regRefused)
    else $error("access not answered once");
  a_quiet_idle: assert property (!regWrite && !regRead |=> !regAck && !regRefused)
    else $error("answer without request");
  a_refuse_down: assert property ((regWrite || regRead) && !powerdown_n |=> regRefused)
    else $error("access taken in power-down");
  property p_drive;
    logic [1:0] d;
    (regWrite && regAddr == 16'h3011, d = regWrData[6:5]) ##1 regAck |-> ##[0:2] padDrive == d;
  endproperty
  a_drive_code: assert property (p_drive)
    else $error("drive code not applied");
  a_lane_map: assert property (!hwStandby && !$past(hwStandby) && $stable(laneSelect)
    |-> laneEnable == (laneSelect == 2'h0 ? 4'h1 : laneSelect == 2'h1 ? 4'h3 : 4'hf))
    else $error("lane enables wrong");
  a_down_clock: assert property (!powerdown_n |=> !intClockRun)
    else $error("clock runs in power-down");
  a_sw_clock: assert property (swStandby && !hwStandby && $past(swStandby && !hwStandby)
    |-> intClockRun)
    else $error("clock stopped in software standby");
  a_drain_frame: assert property (sensorActive && frameInProgress && !frameEnd |=> !swStandby)
    else $error("standby entered mid-frame");
  a_first_frame: assert property (frameStartGo |-> waitCnt >= exposureLines * LINE_CYCLES
    && waitCnt <= FIRST_FRAME_CYCLES + exposureLines * LINE_CYCLES + 4)
    else $error("first frame start out of window");
  a_shut_pads: assert property (@(posedge clk) disable iff (sys_rst)
    !shutdown_n |-> !ctrlBusEnable && !mipiPadOe && hwStandby)
    else $error("pads active in shutdown");

  c_frame: cover property (frameStartGo);
  c_refused: cover property (regRefused);
  c_drained: cover property (sensorActive ##1 swStandby);
endmodule

bind sensor_power_standby_ctrl power_ctrl_checker
  #(.FIRST_FRAME_CYCLES(FIRST_FRAME_CYCLES), .LINE_CYCLES(LINE_CYCLES)) chk (.*);

// file: sim/host_pins.sv
// host-side model of the power pins and supply
// pins move on the falling edge; the input clock always runs
module host_pins
(
  // clock
  input wire clk,
  // bench requests
  input wire wantOn,
  input wire pwdnReq,
  // observed bus and frame traffic
  input wire regWrite,
  input wire regRead,
  input wire frameEnd,
  // pins and supply
  output reg shutdown_n,
  output reg powerdown_n,
  output reg coreSupplyGood,
  // first bus transaction allowed
  output reg busReady
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [13:0] onCnt;
  reg [9:0] quietCnt;

  initial
  begin
    {shutdown_n, coreSupplyGood, busReady, onCnt, quietCnt} = 0;
    powerdown_n = 1'b1;
  end

  // quiet time since the last transaction or frame end
  always @(posedge clk)
  begin
    if (regWrite || regRead || frameEnd)
      quietCnt <= 10'h0;
    else if (quietCnt != 10'h3ff)
      quietCnt <= quietCnt + 10'h1;
  end

  // supply first, then shutdown; the reverse going down
  always @(negedge clk)
  begin
    powerdown_n <= !pwdnReq;
    if (wantOn)
    begin
      coreSupplyGood <= 1'b1;
      shutdown_n <= coreSupplyGood;
      onCnt <= (shutdown_n && onCnt != 14'h2000) ? onCnt + 14'h1 : onCnt;
      busReady <= (onCnt == 14'h2000);
    end
    else
    begin
      busReady <= 1'b0;
      onCnt <= 14'h0;
      if (quietCnt >= 10'h200)
        shutdown_n <= 1'b0;
      if (!shutdown_n)
        coreSupplyGood <= 1'b0;
    end
  end
endmodule

// file: sim/test_sensor_power_standby_ctrl.sv
// self-checking bench for the reset, standby and pad block
// short first-frame and line counts; host model drives pins and supply
module test_sensor_power_standby_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam FF = 20;
  localparam LC = 4;
  reg clk, sys_rst, regWrite, regRead, frameInProgress, frameEnd, vsyncData, lineValidData, wantOn, pwdnReq;
  reg [15:0] regAddr, exposureLines;
  reg [7:0] regWrData;
  reg [1:0] laneSelect;
  wire shutdown_n, powerdown_n, coreSupplyGood, busReady, regAck, regRefused, sensorActive, frameStartGo;
  wire swStandby, hwStandby, intClockRun, vsyncOut, vsyncOe, lineValidOut, lineValidOe, gpioOut, gpioOe;
  wire ctrlBusEnable, mipiPadOe, mipiPadIdleHigh;
  wire [7:0] regRdData;
  wire [3:0] laneEnable;
  wire [1:0] padDrive;
  wire [95:0] addrs = {16'h0100, 16'h0103, 16'h3002, 16'h300d, 16'h3010, 16'h3011};
  integer num_errors, n_compared, i, n, fcnt;

  sensor_power_standby_ctrl #(.FIRST_FRAME_CYCLES(FF), .LINE_CYCLES(LC)) dut (.*);
  host_pins host (.*);

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task check(input [7:0] seen, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask

  task summarize;
  begin
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  // one-cycle request; answer stands in the cycle after the taking edge
  // ans 3 leaves the answer unchecked; read data expected in d
  task acc(input w, input [15:0] a, input [7:0] d, input [1:0] ans);
  begin
    @(negedge clk);
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWrData = d;
    @(negedge clk);
    regWrite = 1'b0;
    regRead = 1'b0;
    if (ans != 2'h3)
      check({6'h0, regRefused, regAck}, {6'h0, ans});
    if (!w && ans == 2'h1)
      check(regRdData, d);
  end
  endtask

  // bounded wait: 0 bus ready, 1 frame start, 2 standby, 3 shutdown low
  task waitOn(input [1:0] sel, input integer lim, output integer k);
  begin
    k = 0;
    while (k < lim && (sel == 0 ? busReady : sel == 1 ? frameStartGo : sel == 2 ? swStandby : !shutdown_n) !== 1'b1)
    begin
      @(negedge clk);
      k = k + 1;
    end
    if (k >= lim)
    begin
      num_errors = num_errors + 1;
      $display("ERROR %0t: wait ran out", $time);
      summarize;
    end
  end
  endtask

  // frame stand-in: 12-cycle frames while the sensor is active
  always @(negedge clk)
  begin
    frameEnd <= 1'b0;
    if (frameInProgress)
    begin
      fcnt <= fcnt + 1;
      if (fcnt == 11)
      begin
        frameInProgress <= 1'b0;
        frameEnd <= 1'b1;
      end
    end
    else if (sensorActive && !frameEnd)
    begin
      frameInProgress <= 1'b1;
      fcnt <= 0;
    end
  end

  initial
  begin
    {regWrite, regRead, regAddr, regWrData, laneSelect, vsyncData, lineValidData, frameInProgress, frameEnd} = 0;
    {wantOn, pwdnReq, num_errors, n_compared, fcnt} = 0;
    sys_rst = 1'b1;
    exposureLines = 16'h3;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    wantOn <= 1'b1;
    acc(1'b1, 16'h3011, 8'h60, 2'h0);
    check(hwStandby, 1'b1);
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h3011, 8'h00, 2'h2);
    waitOn(0, 20000, n);
    check({swStandby, sensorActive, intClockRun, hwStandby}, 4'ha);
    for (i = 0; i < 6; i = i + 1)
      acc(1'b0, addrs[i * 16 +: 16], 8'h00, 2'h1);
    $display("power-up done");
    vsyncData = 1'b0;
    lineValidData = 1'b1;
    acc(1'b1, 16'h3002, 8'hc1, 2'h1);
    acc(1'b1, 16'h300d, 8'h81, 2'h1);
    acc(1'b1, 16'h3010, 8'hc0, 2'h1);
    repeat (2) @(negedge clk);
    check({vsyncOe, lineValidOe, gpioOe, vsyncOut, lineValidOut, gpioOut}, 8'h3d);
    acc(1'b1, 16'h3010, 8'h00, 2'h1);
    repeat (2) @(negedge clk);
    check({vsyncOut, lineValidOut}, 2'h1);
    acc(1'b1, 16'h1234, 8'h55, 2'h1);
    acc(1'b0, 16'h1234, 8'h00, 2'h1);
    for (i = 0; i < 4; i = i + 1)
    begin
      laneSelect = i[1:0];
      acc(1'b1, 16'h3011, {1'b0, i[1:0], 5'h0}, 2'h1);
      repeat (2) @(negedge clk);
      check(padDrive, i[1:0]);
      check(laneEnable, i == 0 ? 4'h1 : i == 1 ? 4'h3 : 4'hf);
    end
    $display("pads and lanes done");
    acc(1'b1, 16'h0100, 8'h01, 2'h1);
    waitOn(1, 200, n);
    check(n >= FF + 3 * LC - 2 && n <= FF + 3 * LC + 6, 1'b1);
    repeat (3) @(negedge clk);
    check(sensorActive, 1'b1);
    acc(1'b1, 16'h0100, 8'h00, 2'h1);
    @(negedge clk);
    check({swStandby, frameInProgress}, 2'h1);
    waitOn(2, 40, n);
    check(frameInProgress, 1'b0);
    acc(1'b1, 16'h0100, 8'h01, 2'h1);
    acc(1'b1, 16'h0100, 8'h00, 2'h1);
    waitOn(2, 4, n);
    check(swStandby, 1'b1);
    acc(1'b0, 16'h3002, 8'hc1, 2'h1);
    $display("streaming done");
    pwdnReq <= 1'b1;
    repeat (3) @(negedge clk);
    check({intClockRun, gpioOe, gpioOut}, 3'h3);
    acc(1'b0, 16'h3002, 8'h00, 2'h2);
    pwdnReq <= 1'b0;
    repeat (3) @(negedge clk);
    acc(1'b0, 16'h3002, 8'hc1, 2'h1);
    acc(1'b1, 16'h0103, 8'h01, 2'h3);
    acc(1'b0, 16'h3002, 8'h00, 2'h1);
    acc(1'b0, 16'h300d, 8'h00, 2'h1);
    $display("power-down and soft reset done");
    acc(1'b1, 16'h3002, 8'h81, 2'h1);
    wantOn <= 1'b0;
    waitOn(3, 700, n);
    @(negedge clk);
    check({ctrlBusEnable, mipiPadOe, vsyncOe, hwStandby}, 4'h1);
    acc(1'b0, 16'h3002, 8'h00, 2'h0);
    wantOn <= 1'b1;
    waitOn(0, 20000, n);
    check({mipiPadOe, mipiPadIdleHigh}, 2'h3);
    acc(1'b0, 16'h3002, 8'h00, 2'h1);
    $display("shutdown done");
    summarize;
  end
endmodule
